// ==== src/las_pkg.sv ====
// Package for the load-adaptive step execution block
package las_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] REG_DIAG_CFG   = 4'h0;
   localparam logic [3:0] REG_ADAPT_CFG  = 4'h1;
   localparam logic [3:0] REG_MIN_VEL    = 4'h2;
   localparam logic [3:0] REG_LOAD_CFG   = 4'h3;
   localparam logic [3:0] REG_LOST_STEPS = 4'h4;
   localparam logic [3:0] REG_STATUS     = 4'h5;
   localparam logic [3:0] REG_QUIET_THR  = 4'h6;

   // Diagnostic signal selections
   localparam logic [1:0] SEL_STALL = 2'h0;
   localparam logic [1:0] SEL_INDEX = 2'h1;
   localparam logic [1:0] SEL_CHOP  = 2'h2;
   localparam logic [1:0] SEL_SKIP  = 2'h3;

   // Field positions in REG_DIAG_CFG
   localparam int DIAG_SEL0_LSB = 0;
   localparam int DIAG_SEL1_LSB = 2;
   localparam int DIAG_PP_BIT   = 4;

   // Field positions in REG_ADAPT_CFG
   localparam int CHOPPER_OFF_TIME_LSB    = 0;
   localparam int VHIGHFS_BIT = 4;
   localparam int VHIGHCM_BIT = 5;
   localparam int QUIET_BIT   = 6;

   // Field positions in REG_LOAD_CFG
   localparam int REFPW_LSB = 0;
   localparam int SENS_LSB  = 16;

   // Limits and reset values
   localparam logic [3:0]  CHOPPER_OFF_TIME_CAP      = 4'h8;
   localparam logic [31:0] DIAG_CFG_RST  = 32'h0000_0000;
   localparam logic [31:0] ADAPT_CFG_RST = 32'h0000_0033;
   localparam logic [31:0] LOAD_CFG_RST  = 32'h0004_0040;
   localparam logic [22:0] MIN_VEL_RST   = 23'h00_0000;
   localparam logic [9:0]  LOAD_MAX      = 10'h1FF;

   // Step override time
   localparam int OVR_NS     = 102400;
   localparam int CLK_NS     = 100;
   localparam int OVR_CYCLES = (OVR_NS + CLK_NS - 1) / CLK_NS;

   // Software register fields
   typedef struct packed {
      logic [1:0]  sel0;
      logic [1:0]  sel1;
      logic        push_pull;
      logic [3:0]  off_time;
      logic        vhighfs;
      logic        vhighchm;
      logic        quiet_en;
      logic [22:0] min_vel;
      logic [22:0] quiet_thr;
      logic [9:0]  ref_pw;
      logic [7:0]  sens;
   } las_cfg_s;

endpackage : las_pkg

// ==== src/las_step_exec.sv ====
// Load-adaptive step execution with two diagnostic outputs
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

// Operation
// - software selects diag signals and output type
// - first diag output low during reset
// - stall selection reports detected stall
// - index selection asserts at counter zero
// - index lasts the zero microstep
// - chopper selection alternates coil on-phases
// - skipped selection toggles per step not taken in adaptive mode
// - follow rate, slow on overload, flag stall
// - load value kept, up to 511
// - off time above 8 acts as 8, capped only while adaptive
// - zero threshold disables; keep minimum velocity
// - quiet chopper below its threshold disables load-adaptive mode
// - reference pulse width 0 to 1023
// - stall sensitivity 0 to 255
// - lost-step counter readable by software
// - adaptive mode forces slow-decay off-time chopper
// - force input or velocity-based activation
// - ready low while step cannot be taken
// - buffer steps up to microsteps per fullstep
// - long step pulse or min velocity overrides
// - sync input holds steps, ready inactive
// - lost steps count by direction
module las_step_exec #(
   parameter int MSTEP_PER_FS = 16,
   parameter int LOST_W       = 20
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   // Register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Step and direction from controller
   input  wire logic        step_in,
   input  wire logic        dir_in,
   input  wire logic        adaptive_mode_force_in,
   input  wire logic        sync_hold_in,
   // Motor state from sequencer and chopper
   input  wire logic        motor_ready_in,
   input  wire logic        stall_detect_in,
   input  wire logic [9:0]  load_value_in,
   input  wire logic [9:0]  mscnt_in,
   input  wire logic        chop_on_a_in,
   input  wire logic        chop_on_b_in,
   input  wire logic [22:0] velocity_in,
   // Outputs to sequencer and chopper
   output logic             exec_step_out,
   output logic             exec_dir_out,
   output logic             fullstep_mode_out,
   output logic             const_off_out,
   output logic [3:0]       eff_off_time_out,
   // Pins to controller
   output logic             step_ready_out,
   output logic             diag_out_first,
   output logic             diag_oe_first_out,
   output logic             diag_out_second,
   output logic             diag_oe_second_out
);

   localparam int BUF_W = $clog2(MSTEP_PER_FS + 1);

   // Refuse sizes the buffer and counters cannot serve
   if (MSTEP_PER_FS < 1 || MSTEP_PER_FS > 256)
   begin : g_bad_mstep
      $error("las_step_exec: MSTEP_PER_FS out of range");
   end
   if (LOST_W < 2 || LOST_W > 32)
   begin : g_bad_lost
      $error("las_step_exec: LOST_W out of range");
   end
   if (las_pkg::OVR_CYCLES < 1 || las_pkg::OVR_CYCLES > 2047)
   begin : g_bad_ovr
      $error("las_step_exec: override count exceeds counter");
   end

   typedef struct packed {
      las_pkg::las_cfg_s   cfg;
      logic [LOST_W-1:0]   lost;
      logic [BUF_W-1:0]    pend;
      logic [10:0]         hi_cnt;
      logic                step_d;
      logic                ovr_done;
      logic                stall;
      logic [9:0]          load;
      logic                skip_tgl;
      logic                chop_sel;
      logic [31:0]         rdata;
      logic                exec;
      logic                dir;
      logic                fs;
      logic                coff;
      logic [3:0]          chopper_off_time;
      logic                ready;
      logic                d0;
      logic                d0_oe;
      logic                d1;
      logic                d1_oe;
      logic [22:0]         minv_acc;
   } las_state_s;

   las_state_s st_reg;
   las_state_s st_next;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      logic       active;
      logic       rise;
      logic       ovr;
      logic       minv_tick;
      logic       can_step;
      logic       take;
      logic       skipped;
      logic [3:0] sig;
      logic [22:0] acc_sum;
      active    = 1'b0;
      rise      = 1'b0;
      ovr       = 1'b0;
      minv_tick = 1'b0;
      can_step  = 1'b0;
      take      = 1'b0;
      skipped   = 1'b0;
      sig       = 4'h0;
      acc_sum   = 23'h0;
      st_next   = st_reg;

      // Register writes take effect at the next edge
      // Writes to read-only or unmapped indices are dropped
      // Fields outside the defined bits are ignored
      // Register writes
      if (reg_wr_in)
      begin
         if (reg_addr_in == las_pkg::REG_DIAG_CFG)
         begin
            st_next.cfg.sel0 = reg_wdata_in[las_pkg::DIAG_SEL0_LSB +: 2];
            st_next.cfg.sel1 = reg_wdata_in[las_pkg::DIAG_SEL1_LSB +: 2];
            st_next.cfg.push_pull = reg_wdata_in[las_pkg::DIAG_PP_BIT];
         end
         else if (reg_addr_in == las_pkg::REG_ADAPT_CFG)
         begin
            st_next.cfg.off_time = reg_wdata_in[las_pkg::CHOPPER_OFF_TIME_LSB +: 4];
            st_next.cfg.vhighfs  = reg_wdata_in[las_pkg::VHIGHFS_BIT];
            st_next.cfg.vhighchm = reg_wdata_in[las_pkg::VHIGHCM_BIT];
            st_next.cfg.quiet_en = reg_wdata_in[las_pkg::QUIET_BIT];
         end
         else if (reg_addr_in == las_pkg::REG_MIN_VEL)
            st_next.cfg.min_vel = reg_wdata_in[22:0];
         else if (reg_addr_in == las_pkg::REG_LOAD_CFG)
         begin
            st_next.cfg.ref_pw = reg_wdata_in[las_pkg::REFPW_LSB +: 10];
            st_next.cfg.sens   = reg_wdata_in[las_pkg::SENS_LSB +: 8];
         end
         else if (reg_addr_in == las_pkg::REG_QUIET_THR)
            st_next.cfg.quiet_thr = reg_wdata_in[22:0];
      end

      // Adaptive mode needs a nonzero velocity floor
      // Force input or quiet threshold may switch it on
      // Quiet chopper below its threshold always vetoes it
      // Velocity below the floor falls back to microsteps
      // Mode activation
      active = (adaptive_mode_force_in
                || (st_reg.cfg.quiet_en
                    && velocity_in >= st_reg.cfg.quiet_thr))
               && !(st_reg.cfg.quiet_en
                    && velocity_in < st_reg.cfg.quiet_thr)
               && (st_reg.cfg.min_vel != 23'h0)
               && (velocity_in >= st_reg.cfg.min_vel);

      // Step input is sampled once per clock
      // A rising edge requests one step into the buffer
      // A pulse held high past the override count
      // releases one blocked step, once per pulse
      // Step edge and long pulse detection
      rise = step_in && !st_reg.step_d;
      st_next.step_d = step_in;
      if (!step_in)
      begin
         st_next.hi_cnt   = 11'h0;
         st_next.ovr_done = 1'b0;
      end
      else if (st_reg.hi_cnt < 11'(las_pkg::OVR_CYCLES))
         st_next.hi_cnt = st_reg.hi_cnt + 11'h1;
      ovr = step_in && !st_reg.ovr_done
            && st_reg.hi_cnt >= 11'(las_pkg::OVR_CYCLES);
      if (ovr)
         st_next.ovr_done = 1'b1;

      // Phase accumulator gives the floor step rate
      // Carry out of the top bit is one paced step
      // Cleared while inactive so pacing restarts cleanly
      // Minimum velocity pacing while blocked
      acc_sum = st_reg.minv_acc + st_reg.cfg.min_vel;
      minv_tick = active && (acc_sum < st_reg.minv_acc);
      st_next.minv_acc = active ? acc_sum : 23'h0;

      // Steps queue while the motor is not ready
      // Buffer holds up to one fullstep of microsteps
      // Edges beyond that are counted as not taken while adaptive
      // At most one buffered step leaves per clock
      // Sync hold freezes the buffer output entirely
      // Step execution and buffering
      can_step = !active || motor_ready_in || ovr || minv_tick;
      st_next.exec = 1'b0;
      if (rise)
      begin
         if (st_reg.pend < BUF_W'(MSTEP_PER_FS))
            st_next.pend = st_reg.pend + BUF_W'(1);
         else
            skipped = 1'b1;
      end
      take = (st_next.pend != '0) && can_step && !sync_hold_in;
      if (take)
      begin
         st_next.pend = st_next.pend - BUF_W'(1);
         st_next.exec = 1'b1;
      end
      st_next.dir = dir_in;

      // Counter wraps; software reads it as signed
      // Forward direction counts up, reverse counts down
      // Lost steps, counted by direction
      if (skipped && active)
      begin
         st_next.lost = dir_in ? st_reg.lost - LOST_W'(1)
                               : st_reg.lost + LOST_W'(1);
         st_next.skip_tgl = !st_reg.skip_tgl;
      end

      // Ready falls while sync hold is applied
      // or while an active motor has not settled
      // Ready handshake
      st_next.ready = !sync_hold_in && (!active || motor_ready_in);

      // Fullstep only when both high-velocity flags set
      // Constant off-time follows adaptive mode directly
      // Off time is capped only while adaptive
      // Chopper forcing
      st_next.fs   = active && st_reg.cfg.vhighfs
                     && st_reg.cfg.vhighchm;
      st_next.coff = active;
      st_next.chopper_off_time = (active && st_reg.cfg.off_time > las_pkg::CHOPPER_OFF_TIME_CAP)
                     ? las_pkg::CHOPPER_OFF_TIME_CAP : st_reg.cfg.off_time;

      // Stall latches while blocked in adaptive mode
      // Leaving adaptive mode clears the stall flag
      // Load value is clamped to its documented span
      // Stall and load
      if (active && stall_detect_in && !motor_ready_in)
         st_next.stall = 1'b1;
      else if (!active)
         st_next.stall = 1'b0;
      st_next.load = (load_value_in > las_pkg::LOAD_MAX)
                     ? las_pkg::LOAD_MAX : load_value_in;

      // Free-running selector shares one pin between coils
      // Chopper on-state alternates coils each cycle
      st_next.chop_sel = !st_reg.chop_sel;

      // Open drain pulls low when the signal is active
      // Push-pull always drives, high when active
      // Pins lag their source by one clock
      // Diagnostic signals, active high before polarity
      sig[las_pkg::SEL_STALL] = st_reg.stall;
      sig[las_pkg::SEL_INDEX] = (mscnt_in == 10'h0);
      sig[las_pkg::SEL_CHOP]  = st_reg.chop_sel ? chop_on_b_in
                                                : chop_on_a_in;
      sig[las_pkg::SEL_SKIP]  = st_reg.skip_tgl;
      // Index follows counter each cycle, so lasts the microstep
      st_next.d0 = st_reg.cfg.push_pull ? sig[st_reg.cfg.sel0]
                                        : 1'b0;
      st_next.d0_oe = st_reg.cfg.push_pull || sig[st_reg.cfg.sel0];
      st_next.d1 = st_reg.cfg.push_pull ? sig[st_reg.cfg.sel1] : 1'b0;
      st_next.d1_oe = st_reg.cfg.push_pull || sig[st_reg.cfg.sel1];

      // Read data stands for one cycle, else zero
      // Unmapped indices read as zero
      // Register reads
      st_next.rdata = 32'h0;
      if (reg_rd_in)
      begin
         if (reg_addr_in == las_pkg::REG_DIAG_CFG)
            st_next.rdata = {27'h0, st_reg.cfg.push_pull,
                             st_reg.cfg.sel1, st_reg.cfg.sel0};
         else if (reg_addr_in == las_pkg::REG_ADAPT_CFG)
            st_next.rdata = {25'h0, st_reg.cfg.quiet_en,
                             st_reg.cfg.vhighchm, st_reg.cfg.vhighfs,
                             st_reg.cfg.off_time};
         else if (reg_addr_in == las_pkg::REG_MIN_VEL)
            st_next.rdata = {9'h0, st_reg.cfg.min_vel};
         else if (reg_addr_in == las_pkg::REG_LOAD_CFG)
            st_next.rdata = {8'h0, st_reg.cfg.sens, 6'h0, st_reg.cfg.ref_pw};
         else if (reg_addr_in == las_pkg::REG_LOST_STEPS)
            st_next.rdata = 32'(signed'(st_reg.lost));
         else if (reg_addr_in == las_pkg::REG_STATUS)
            st_next.rdata = {19'h0, st_reg.ready, st_reg.stall,
                             active, st_reg.load};
         else if (reg_addr_in == las_pkg::REG_QUIET_THR)
            st_next.rdata = {9'h0, st_reg.cfg.quiet_thr};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Synchronous reset loads configuration defaults
   // First diag pin is pulled low throughout reset
   // Ready starts high so the first step is accepted
   // State register
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_reg <= '0;
         st_reg.cfg.off_time <= las_pkg::ADAPT_CFG_RST[3:0];
         st_reg.cfg.vhighfs  <= las_pkg::ADAPT_CFG_RST[las_pkg::VHIGHFS_BIT];
         st_reg.cfg.vhighchm <= las_pkg::ADAPT_CFG_RST[las_pkg::VHIGHCM_BIT];
         st_reg.cfg.min_vel  <= las_pkg::MIN_VEL_RST;
         st_reg.cfg.ref_pw   <= las_pkg::LOAD_CFG_RST[9:0];
         st_reg.cfg.sens     <= las_pkg::LOAD_CFG_RST[23:16];
         st_reg.d0    <= 1'b0;
         st_reg.d0_oe <= 1'b1;
         st_reg.ready <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////
   // No logic between flip-flops and pins
   // Outputs straight from the state register
   assign reg_rdata_out      = st_reg.rdata;
   assign exec_step_out      = st_reg.exec;
   assign exec_dir_out       = st_reg.dir;
   assign fullstep_mode_out  = st_reg.fs;
   assign const_off_out      = st_reg.coff;
   assign eff_off_time_out   = st_reg.chopper_off_time;
   assign step_ready_out     = st_reg.ready;
   assign diag_out_first     = st_reg.d0;
   assign diag_oe_first_out  = st_reg.d0_oe;
   assign diag_out_second    = st_reg.d1;
   assign diag_oe_second_out = st_reg.d1_oe;

endmodule : las_step_exec

// ==== testbench/las_step_chk.sv ====
// Port assertions for the load-adaptive step execution block
`timescale 1ns/1ps
module las_step_chk (
   // Clock, reset and register writes
   input wire logic        clk_in,
   input wire logic        srst_in,
   input wire logic [3:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   // Controller and sequencer side
   input wire logic        step_in,
   input wire logic        sync_hold_in,
   input wire logic        motor_ready_in,
   input wire logic [9:0]  mscnt_in,
   // Observed outputs
   input wire logic        exec_step_out,
   input wire logic        fullstep_mode_out,
   input wire logic        const_off_out,
   input wire logic [3:0]  eff_off_time_out,
   input wire logic        step_ready_out,
   input wire logic        diag_out_first,
   input wire logic        diag_oe_first_out
);
   logic [4:0] dcfg_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // Shadow of the diagnostic configuration
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         dcfg_reg <= 5'h00;
      else if (reg_wr_in && reg_addr_in == las_pkg::REG_DIAG_CFG)
         dcfg_reg <= reg_wdata_in[4:0];
   end
   //////////////////////////////////////////////////////////////////////
   a_reset_pulls_first: assert property (disable iff (1'b0)
      srst_in |=> !diag_out_first && diag_oe_first_out) else $error("reset");
   a_sync_ready_low: assert property (sync_hold_in |=> !step_ready_out)
      else $error("ready not low on sync");
   a_sync_no_exec: assert property (sync_hold_in |=> !exec_step_out)
      else $error("step during sync hold");
   a_ready_on_motor: assert property (
      !sync_hold_in && motor_ready_in |=> step_ready_out) else $error("ready");
   a_adapt_const_off: assert property (
      fullstep_mode_out |-> const_off_out) else $error("chopper mode");
   a_off_time_cap: assert property (
      const_off_out |-> eff_off_time_out <= las_pkg::CHOPPER_OFF_TIME_CAP) else $error("off");
   a_index_push: assert property (dcfg_reg[4] && mscnt_in == 10'h000
      && dcfg_reg[1:0] == las_pkg::SEL_INDEX |=> diag_out_first)
      else $error("index");
   a_drain_never_high: assert property (
      !dcfg_reg[4] |=> !diag_out_first) else $error("open drain");
   a_step_follow: assert property ($rose(step_in) && !sync_hold_in
      && !fullstep_mode_out |-> ##[1:3] exec_step_out) else $error("step");
   // Main scenarios
   c_exec: cover property (exec_step_out);
   c_sync_step: cover property (sync_hold_in && step_in);
   c_wait: cover property (fullstep_mode_out && !step_ready_out);
endmodule : las_step_chk
bind las_step_exec las_step_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .step_in(step_in), .sync_hold_in(sync_hold_in),
   .motor_ready_in(motor_ready_in), .mscnt_in(mscnt_in),
   .exec_step_out(exec_step_out), .fullstep_mode_out(fullstep_mode_out),
   .const_off_out(const_off_out), .eff_off_time_out(eff_off_time_out),
   .step_ready_out(step_ready_out), .diag_out_first(diag_out_first),
   .diag_oe_first_out(diag_oe_first_out));

// ==== testbench/las_ctrl_model.sv ====
// Motion controller model driving step and direction
`timescale 1ns/1ps
module las_ctrl_model (
   // Clock and ready from the driver
   input  wire logic clk_in,
   input  wire logic step_ready_in,
   // Step and direction pins
   output logic      step_out,
   output logic      dir_out
);
   int to_cnt = 0;
   initial
   begin
      step_out = 1'b0;
      dir_out  = 1'b0;
   end
   // One step pulse, optionally held off until ready
   task automatic pulse(input logic dir, input int hold, input logic wt);
      int n;
      n = 0;
      while (wt && step_ready_in !== 1'b1 && n < 2000)
      begin
         @(posedge clk_in);
         n++;
      end
      if (n == 2000)
         to_cnt++;
      dir_out <= dir;
      @(posedge clk_in);
      step_out <= 1'b1;
      repeat (hold) @(posedge clk_in);
      step_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : pulse
endmodule : las_ctrl_model

// ==== testbench/las_step_exec_tb.sv ====
// Self-checking bench for the load-adaptive step execution block
`timescale 1ns/1ps
module las_step_exec_tb;
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, v;
   logic        wr = 1'b0, rd = 1'b0, force_en = 1'b1, sync = 1'b0;
   logic        mrdy = 1'b0, stall = 1'b0, v0;
   logic        chop_a = 1'b0, edir;
   logic [9:0]  load = 10'h000, mscnt = 10'h005;
   logic [22:0] vel = 23'h000064;
   logic [31:0] rdata;
   logic        step, dir, rdy, d0, oe0, d1, oe1, exe, fs, co;
   logic [3:0]  eff;
   int          error_cnt = 0, comparisons = 0, exec_cnt = 0, n0;
   las_step_exec #(.MSTEP_PER_FS(4)) dut (.clk_in(clk_in),
      .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .step_in(step), .dir_in(dir), .adaptive_mode_force_in(force_en),
      .sync_hold_in(sync), .motor_ready_in(mrdy), .stall_detect_in(stall),
      .load_value_in(load), .mscnt_in(mscnt), .chop_on_a_in(chop_a),
      .chop_on_b_in(1'b0), .velocity_in(vel), .exec_step_out(exe),
      .exec_dir_out(edir), .fullstep_mode_out(fs), .const_off_out(co),
      .eff_off_time_out(eff), .step_ready_out(rdy), .diag_out_first(d0),
      .diag_oe_first_out(oe0), .diag_out_second(d1),
      .diag_oe_second_out(oe1));
   las_ctrl_model ctrl (.clk_in(clk_in), .step_ready_in(rdy),
      .step_out(step), .dir_out(dir));
   // Clock and executed-step counter
   initial forever #50 clk_in = ~clk_in;
   always @(posedge clk_in) if (exe === 1'b1) exec_cnt++;
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s: expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input string s, input logic [3:0] a,
                       input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 v = rdata;
      chk(s, e, v & m);
   endtask : rchk
   task automatic tally_and_finish;
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   //////////////////////////////////////////////////////////////////////
   // Watchdog against a hang
   initial
   begin
      repeat (100000) @(posedge clk_in);
      error_cnt++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_in);
      srst_in <= 1'b0;
      chk("diag_reset", 32'h2, {29'h0, oe1, oe0, d0});
      rchk("diag_cfg", las_pkg::REG_DIAG_CFG, '1, las_pkg::DIAG_CFG_RST);
      rchk("adapt_cfg", las_pkg::REG_ADAPT_CFG, '1, las_pkg::ADAPT_CFG_RST);
      rchk("min_vel", las_pkg::REG_MIN_VEL, '1, 32'h0);
      rchk("unmapped", 4'hF, '1, 32'h0);
      wreg(las_pkg::REG_LOAD_CFG, 32'h00FF03FF);
      rchk("load_cfg", las_pkg::REG_LOAD_CFG, '1, 32'h00FF03FF);
      n0 = exec_cnt;
      ctrl.pulse(1'b0, 2, 1'b1);
      chk("plain_step", n0 + 1, exec_cnt);
      load <= 10'h3FF;
      wreg(las_pkg::REG_MIN_VEL, 32'h1);
      wreg(las_pkg::REG_ADAPT_CFG, 32'h3F);
      rchk("active", las_pkg::REG_STATUS, 32'h7FF, 32'h5FF);
      chk("chopper", 32'h38, {26'h0, fs, co, eff});
      chk("ready_low", 32'h0, {31'h0, rdy});
      wreg(las_pkg::REG_DIAG_CFG, 32'h1D);
      repeat (2) @(posedge clk_in);
      v0 = d1;
      for (int i = 0; i < 7; i++)
         ctrl.pulse(1'b0, 2, 1'b0);
      rchk("lost_fwd", las_pkg::REG_LOST_STEPS, '1, 32'h3);
      chk("lost_mag", 32'h1, {31'h0, v == 32'h3 || v == 32'hFFFFFFFD});
      chk("skip_toggle", {31'h0, ~v0}, {31'h0, d1});
      for (int i = 0; i < 3; i++)
         ctrl.pulse(1'b1, 2, 1'b0);
      rchk("lost_back", las_pkg::REG_LOST_STEPS, '1, 32'h0);
      chk("exec_dir", 32'h1, {31'h0, edir});
      n0 = exec_cnt;
      mrdy <= 1'b1;
      mscnt <= 10'h000;
      repeat (20) @(posedge clk_in);
      chk("buffered", n0 + 4, exec_cnt);
      chk("index_on", 32'h3, {30'h0, oe0, d0});
      mscnt <= 10'h005;
      sync <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk("index_off", 32'h2, {30'h0, oe0, d0});
      chk("sync_ready", 32'h0, {31'h0, rdy});
      n0 = exec_cnt;
      ctrl.pulse(1'b0, 2, 1'b0);
      chk("sync_hold", n0, exec_cnt);
      sync <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk("sync_release", n0 + 1, exec_cnt);
      mrdy <= 1'b0;
      n0 = exec_cnt;
      ctrl.pulse(1'b0, 1100, 1'b0);
      chk("override", n0 + 1, exec_cnt);
      wreg(las_pkg::REG_DIAG_CFG, 32'h1C);
      stall <= 1'b1;
      rchk("stall", las_pkg::REG_STATUS, 32'h800, 32'h800);
      chk("stall_pin", 32'h3, {30'h0, oe0, d0});
      wreg(las_pkg::REG_QUIET_THR, 32'h007FFFFF);
      wreg(las_pkg::REG_ADAPT_CFG, 32'h7F);
      rchk("quiet_off", las_pkg::REG_STATUS, 32'h400, 32'h0);
      chop_a <= 1'b1;
      wreg(las_pkg::REG_DIAG_CFG, 32'h18);
      repeat (2) @(posedge clk_in);
      v0 = d1;
      @(posedge clk_in);
      chk("chop_alt", 32'h1, {31'h0, d1 ^ v0});
      chk("ctrl_waits", 32'h0, ctrl.to_cnt);
      tally_and_finish();
   end
endmodule : las_step_exec_tb
